// >>> include/timer_regs.vh
// Register offsets, field positions and reset values of the timer unit
//
// How it works
// - A 16-bit counter advances on prescaler ticks; at prescale 0 it advances on every clock.
// - Eight channels do 16-bit capture or compare; one 16-bit pulse accumulator.
// - PWM runs in hardware alone once compare registers are programmed.
// - Pins act as general-purpose lines until a timer function claims them.
// - An enabled output compare forces its pin to output, ignoring direction.
// - Port data writes to an owned pin are latched, driven after release only if its direction bit is set.
// - Function select bit: 0 makes the channel capture, 1 compare.
// - Compare action code: 00 off, 01 toggle, 10 low, 11 high.
// - Capture edge code: 00 off, 01 rising, 10 falling, 11 both.
// - Channel 7 match drives masked compare-mode pins from its data, beating other channels.
// - With reset enable set, channel 7 match clears the counter.
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

`define A_FUNC  8'h00
`define A_CTL   8'h04
`define A_CNT   8'h08
`define A_ACT   8'h0C
`define A_EDGE  8'h10
`define A_PER   8'h14
`define A_PORT  8'h18
`define A_DIR   8'h1C
`define A_STAT  8'h20
`define A_MASK  8'h24
`define A_PIN   8'h28
`define A_ACC   8'h2C
`define A_CHAN  3'h2

`define CTL_EN    0
`define CTL_PR_LO 1
`define CTL_PR_HI 3
`define CTL_COUNTER_RESET_ON_PERIOD_MATCH  4
`define CTL_ACCEN 5
`define CTL_W     6

`define CTL_RST   6'h00
`define PR_MAX    3'h5
`define RESP_OK   2'h0
`define RESP_ERR  2'h2

`endif

// >>> logic/timer_capture_compare_unit.v
// Timer with capture/compare channels, pulse accumulator and AXI4-Lite registers
`include "timer_regs.vh"

module timer_capture_compare_unit #(
  parameter N = 8,
  parameter W = 16
) (
  // Clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  // AXI4-Lite write
  input  wire [7:0]    awaddr,
  input  wire          awvalid,
  output wire          awready,
  input  wire [31:0]   wdata,
  input  wire [3:0]    wstrb,
  input  wire          wvalid,
  output wire          wready,
  output reg  [1:0]    bresp,
  output reg           bvalid,
  input  wire          bready,
  // AXI4-Lite read
  input  wire [7:0]    araddr,
  input  wire          arvalid,
  output wire          arready,
  output reg  [31:0]   rdata,
  output reg  [1:0]    rresp,
  output reg           rvalid,
  input  wire          rready,
  // Timer port pins
  input  wire [N-1:0]  t_in,
  output wire [N-1:0]  t_out,
  output wire [N-1:0]  t_oe,
  // Interrupt
  output wire          irq
);

  localparam P = N - 1;

  reg  [N-1:0]     channel_function_select;
  reg  [`CTL_W-1:0] ctl;
  reg  [2:0]       pr_act;
  reg  [4:0]       pre;
  reg  [W-1:0]     cnt;
  reg  [2*N-1:0]   act;
  reg  [2*N-1:0]   edg;
  reg  [N-1:0]     period_channel_pin_mask;
  reg  [N-1:0]     period_channel_pin_data;
  reg  [N-1:0]     port_latch;
  reg  [N-1:0]     dir;
  reg  [N-1:0]     flags;
  reg  [N-1:0]     imask;
  reg  [W-1:0]     acc;
  reg  [W-1:0]     val [0:N-1];
  reg  [N-1:0]     oc_level;
  reg  [N-1:0]     prev_in;
  reg  [7:0]       aw_a;
  reg  [31:0]      w_d;
  reg  [3:0]       w_s;
  reg              aw_h;
  reg              w_h;
  reg  [N-1:0]     next_level;
  reg  [N-1:0]     match;
  reg  [N-1:0]     cap;
  reg  [N-1:0]     owned;
  reg  [31:0]      rd;
  reg              rd_ok;
  reg  [31:0]      wv;
  reg              wr_ok;
  reg  [4:0]       pmask;
  reg  [7:0]       sel;
  reg  [31:0]      word;
  integer          i;
  integer          j;
  integer          k;

  wire             tick;
  wire             do_wr;
  wire             do_rd;
  wire [N-1:0]     rise;
  wire [N-1:0]     fall;
  wire [31:0]      bm;

  assign awready = !aw_h;
  assign wready  = !w_h;
  assign arready = !rvalid;
  assign do_wr   = aw_h && w_h && !bvalid;
  assign do_rd   = arvalid && !rvalid;
  assign rise    = t_in & ~prev_in;
  assign fall    = ~t_in & prev_in;
  assign irq     = |(flags & imask);
  assign bm      = {{8{w_s[3]}}, {8{w_s[2]}}, {8{w_s[1]}}, {8{w_s[0]}}};

  // Prescaler tick when the selected low stages are all zero
  always @*
  begin
    case (pr_act)
      3'h0:    pmask = 5'h00;
      3'h1:    pmask = 5'h01;
      3'h2:    pmask = 5'h03;
      3'h3:    pmask = 5'h07;
      3'h4:    pmask = 5'h0F;
      default: pmask = 5'h1F;
    endcase
  end
  assign tick = ctl[`CTL_EN] && ((pre & pmask) == 5'h00);

  // Compare, capture and pin ownership
  always @*
  begin
    next_level = oc_level;
    for (j = 0; j < N; j = j + 1)
    begin
      match[j] = tick && channel_function_select[j] && (cnt == val[j]);
      cap[j]   = !channel_function_select[j] &&
                 ((edg[2*j] && rise[j]) || (edg[2*j+1] && fall[j]));
      owned[j] = channel_function_select[j] &&
                 ((act[2*j +: 2] != 2'h0) || period_channel_pin_mask[j]);
      if (match[j])
      begin
        case (act[2*j +: 2])
          2'h1:    next_level[j] = !oc_level[j];
          2'h2:    next_level[j] = 1'b0;
          2'h3:    next_level[j] = 1'b1;
          default: next_level[j] = oc_level[j];
        endcase
      end
    end
    if (match[P])
    begin
      for (j = 0; j < N; j = j + 1)
      begin
        if (period_channel_pin_mask[j])
        begin
          next_level[j] = period_channel_pin_data[j];
        end
      end
    end
  end

  // Owned pins follow compare level; others follow latch and direction
  assign t_oe  = owned | dir;
  assign t_out = (owned & oc_level) | (~owned & port_latch);

  // Register word at the read address, then at the held write address
  always @*
  begin
    rd   = 32'h0000_0000;
    sel  = 8'h00;
    word = 32'h0000_0000;
    for (k = 0; k < 2; k = k + 1)
    begin
      sel  = (k == 0) ? araddr : aw_a;
      word = 32'h0000_0000;
      if (sel[7:5] == `A_CHAN && sel[1:0] == 2'h0)
      begin
        word[W-1:0] = val[sel[4:2]];
      end
      else
      begin
        case (sel)
          `A_FUNC: word[N-1:0]      = channel_function_select;
          `A_CTL:  word[`CTL_W-1:0] = ctl;
          `A_CNT:  word[W-1:0]      = cnt;
          `A_ACT:  word[2*N-1:0]    = act;
          `A_EDGE: word[2*N-1:0]    = edg;
          `A_PER:  word[2*N-1:0]    = {period_channel_pin_data, period_channel_pin_mask};
          `A_PORT: word[N-1:0]      = port_latch;
          `A_DIR:  word[N-1:0]      = dir;
          `A_STAT: word[N-1:0]      = flags;
          `A_MASK: word[N-1:0]      = imask;
          `A_PIN:  word[N-1:0]      = t_in;
          `A_ACC:  word[W-1:0]      = acc;
          default: word = 32'h0000_0000;
        endcase
      end
      rd = (k == 0) ? word : rd;
    end
    // Byte strobes merge new data onto the current word
    wv    = (word & ~bm) | (w_d & bm);
    rd_ok = rd_hit(araddr);
    wr_ok = rd_hit(aw_a);
  end

  function rd_hit;
    input [7:0] a;
    begin
      rd_hit = (a[1:0] == 2'h0) && ((a[7:5] == `A_CHAN) || (a <= `A_ACC));
    end
  endfunction

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_h <= 1'b0;
      w_h <= 1'b0;
      aw_a <= 8'h00;
      w_d <= 32'h0000_0000;
      w_s <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OK;
      rvalid <= 1'b0;
      rresp <= `RESP_OK;
      rdata <= 32'h0000_0000;
      channel_function_select <= {N{1'b0}};
      ctl <= `CTL_RST;
      pr_act <= 3'h0;
      pre <= 5'h00;
      cnt <= {W{1'b0}};
      act <= {2*N{1'b0}};
      edg <= {2*N{1'b0}};
      period_channel_pin_mask <= {N{1'b0}};
      period_channel_pin_data <= {N{1'b0}};
      port_latch <= {N{1'b0}};
      dir <= {N{1'b0}};
      flags <= {N{1'b0}};
      imask <= {N{1'b0}};
      acc <= {W{1'b0}};
      oc_level <= {N{1'b0}};
      prev_in <= {N{1'b0}};
      for (i = 0; i < N; i = i + 1)
      begin
        val[i] <= {W{1'b0}};
      end
    end
    else
    begin
      prev_in <= t_in;
      oc_level <= next_level;
      // Bus channels
      if (awvalid && !aw_h)
      begin
        aw_h <= 1'b1;
        aw_a <= awaddr;
      end
      if (wvalid && !w_h)
      begin
        w_h <= 1'b1;
        w_d <= wdata;
        w_s <= wstrb;
      end
      if (do_wr)
      begin
        aw_h <= 1'b0;
        w_h <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? `RESP_OK : `RESP_ERR;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
      end
      if (do_rd)
      begin
        rvalid <= 1'b1;
        rdata <= rd;
        rresp <= rd_ok ? `RESP_OK : `RESP_ERR;
      end
      else if (rvalid && rready)
      begin
        rvalid <= 1'b0;
      end
      // Prescaler; new factor taken when all stages are zero
      if (ctl[`CTL_EN])
      begin
        pre <= pre + 5'h01;
        if (pre == 5'h00)
        begin
          pr_act <= (ctl[`CTL_PR_HI:`CTL_PR_LO] > `PR_MAX) ? `PR_MAX
                                                            : ctl[`CTL_PR_HI:`CTL_PR_LO];
        end
      end
      if (tick)
      begin
        if (ctl[`CTL_COUNTER_RESET_ON_PERIOD_MATCH] && match[P])
        begin
          cnt <= {W{1'b0}};
        end
        else
        begin
          cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
        end
      end
      // Pulse accumulator counts rising edges on the top pin
      if (ctl[`CTL_ACCEN] && rise[P])
      begin
        acc <= acc + {{(W-1){1'b0}}, 1'b1};
      end
      // Register writes
      if (do_wr && wr_ok)
      begin
        if (aw_a[7:5] == `A_CHAN)
        begin
          val[aw_a[4:2]] <= wv[W-1:0];
        end
        case (aw_a)
          `A_FUNC: channel_function_select <= wv[N-1:0];
          `A_CTL:  ctl <= wv[`CTL_W-1:0];
          `A_ACT:  act <= wv[2*N-1:0];
          `A_EDGE: edg <= wv[2*N-1:0];
          `A_PER:
          begin
            period_channel_pin_mask <= wv[N-1:0];
            period_channel_pin_data <= wv[2*N-1:N];
          end
          `A_PORT: port_latch <= wv[N-1:0];
          `A_DIR:  dir <= wv[N-1:0];
          `A_MASK: imask <= wv[N-1:0];
          `A_ACC:  acc <= wv[W-1:0];
          default: ;
        endcase
      end
      // Captures win over a same-cycle write
      for (i = 0; i < N; i = i + 1)
      begin
        if (cap[i])
        begin
          val[i] <= cnt;
        end
      end
      // Read of status clears it; new events win over the clear
      flags <= (flags & ~((do_rd && araddr == `A_STAT) ? flags : {N{1'b0}}))
               | match | cap;
    end
  end

endmodule // timer_capture_compare_unit

// >>> testbench/timer_capture_compare_unit_monitor.sv
// Checker on the timer unit ports
module timer_capture_compare_unit_monitor #(
  parameter N = 8,
  parameter W = 16
) (
  // Clock and reset
  input wire         aclk,
  input wire         aresetn,
  // Register bus
  input wire         awvalid,
  input wire         awready,
  input wire         wvalid,
  input wire         wready,
  input wire [1:0]   bresp,
  input wire         bvalid,
  input wire         bready,
  input wire [7:0]   araddr,
  input wire         arvalid,
  input wire         arready,
  input wire [31:0]  rdata,
  input wire [1:0]   rresp,
  input wire         rvalid,
  input wire         rready,
  // Pins and interrupt
  input wire [N-1:0] t_out,
  input wire [N-1:0] t_oe,
  input wire         irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped early");
  a_ar_busy: assert property (rvalid && rready |=> arready)
    else $error("read channel not freed after answer");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  a_bad_read: assert property (arvalid && arready && araddr[1:0] != 2'h0
    |=> rresp == 2'h2 && rdata == 32'h0) else $error("unaligned read not refused");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write not answered");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn
    |=> t_oe == '0 && t_out == '0 && !irq && !bvalid) else $error("reset state wrong");
  a_irq_fall: assert property ($fell(irq) |-> rvalid || bvalid || !$past(aresetn))
    else $error("interrupt cleared without software");
  c_write: cover property (bvalid && bready);
  c_irq: cover property ($rose(irq));
  c_pin: cover property ($rose(t_out[N-1:0] != '0));
endmodule // timer_capture_compare_unit_monitor

bind timer_capture_compare_unit timer_capture_compare_unit_monitor #(.N(N), .W(W)) u_mon (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .t_out, .t_oe, .irq);

// >>> testbench/timer_pin_model.sv
// External pin model: loops driven pins back, else applies outside level
module timer_pin_model (
  // Pins
  input  wire [7:0] t_out,
  input  wire [7:0] t_oe,
  output wire [7:0] t_in,
  // Outside level
  input  wire [7:0] ext
);
  timeunit 1ns;
  timeprecision 1ns;
  assign t_in = (t_oe & t_out) | (~t_oe & ext);
endmodule // timer_pin_model

// >>> testbench/tb_timer_capture_compare_unit.sv
// Self-checking bench for the timer unit
`include "timer_regs.vh"
module tb_timer_capture_compare_unit;
  timeunit 1ns;
  timeprecision 1ns;
  reg aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg [7:0] awaddr = 0, araddr = 0, ext = 0;
  reg [31:0] wdata = 0, dd;
  reg [3:0] wstrb = 4'hF;
  reg [1:0] rs;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] t_in, t_out, t_oe;
  integer num_errors = 0, check_count = 0, i, c, h, p;
  reg [73:0] rows [6] = '{{`A_FUNC, 32'h1FF, 32'hFF, 2'h0}, {`A_MASK, 32'hA5, 32'hA5, 2'h0},
    {`A_PER, 32'h12345, 32'h2345, 2'h0}, {`A_CNT, 32'h5, 32'h0, 2'h0},
    {8'hFC, 32'h1, 32'h0, 2'h2}, {8'h02, 32'h1, 32'h0, 2'h2}};
  reg [7:0] ra;
  reg [31:0] rw, re;
  reg [1:0] rr;
  always #20 aclk = ~aclk;
  timer_capture_compare_unit u_timer_capture_compare_unit (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .t_in, .t_out, .t_oe, .irq);
  timer_pin_model u_timer_pin_model (.t_out, .t_oe, .t_in, .ext);
  task conclude;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input [31:0] s, input [31:0] e);
    check_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg ta, tw, dn;
    begin
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1; dn = 0;
      for (i = 0; i < 50 && !dn; i++)
      begin
        @(negedge aclk);
        ta = awvalid && awready; tw = wvalid && wready; dn = bvalid; rs = bresp;
        @(posedge aclk);
        if (ta) awvalid <= 0;
        if (tw) wvalid <= 0;
        if (dn) bready <= 0;
      end
      if (!dn) begin num_errors++; conclude; end
    end
  endtask
  task rd(input [7:0] a);
    reg ta, dn;
    begin
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1; dn = 0;
      for (i = 0; i < 50 && !dn; i++)
      begin
        @(negedge aclk);
        ta = arvalid && arready; dn = rvalid; dd = rdata; rs = rresp;
        @(posedge aclk);
        if (ta) arvalid <= 0;
        if (dn) rready <= 0;
      end
      if (!dn) begin num_errors++; conclude; end
    end
  endtask
  task wp(input [2:0] b, input v);
    for (i = 0; i < 99 && t_out[b] !== v; i++) @(negedge aclk);
    chk("pin", t_out[b], v);
    if (t_out[b] !== v) conclude;
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    chk("oe", t_oe, 0);
    for (c = 0; c < 6; c++)
    begin
      {ra, rw, re, rr} = rows[c];
      wr(ra, rw);
      chk("bresp", rs, rr);
      rd(ra);
      chk("rdata", dd, re);
      chk("rresp", rs, rr);
    end
    wr(`A_FUNC, 0); wr(`A_MASK, 0); wr(`A_PER, 0); wr(`A_CTL, 1);
    for (c = 0; c < 4; c++)
    begin
      wr(`A_EDGE, c); rd(`A_STAT); ext <= 1; repeat (4) @(posedge aclk);
      rd(`A_STAT); chk("rise", dd[0], c[0]);
      ext <= 0; repeat (4) @(posedge aclk);
      rd(`A_STAT); chk("fall", dd[0], c[1]);
    end
    wr(`A_EDGE, 1); wr(`A_MASK, 1); ext <= 1; repeat (4) @(posedge aclk);
    chk("irq", irq, 1);
    wr(`A_MASK, 0); @(negedge aclk); chk("irq", irq, 0);
    wr(`A_MASK, 1); @(negedge aclk); chk("irq", irq, 1);
    rd(`A_STAT); @(negedge aclk); chk("irq", irq, 0);
    @(posedge aclk);
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    chk("oe", t_oe, 0);
    rd(`A_CNT); chk("cnt", dd, 0);
    wr(`A_FUNC, 8'hA0); wr(8'h5C, 8); wr(8'h54, 3); wr(`A_CTL, 6'h11);
    for (c = 3; c > 0; c--)
    begin
      wr(`A_ACT, c << 10); @(negedge aclk); chk("oe5", t_oe[5], 1);
      wp(5, c != 2);
    end
    wr(`A_ACT, 2 << 10); wr(`A_PER, 16'h2020); wr(`A_CTL, 6'h13);
    repeat (32) @(posedge aclk);
    wp(5, 0); wp(5, 1); wp(5, 0); wp(5, 1);
    h = 0;
    do begin @(negedge aclk); h++; end while (t_out[5] === 1'b1 && h < 99);
    p = h;
    do begin @(negedge aclk); p++; end while (t_out[5] === 1'b0 && p < 199);
    chk("high", h, 8);
    chk("period", p, 18);
    wr(`A_PORT, 8'h20); wr(`A_FUNC, 0); @(negedge aclk);
    chk("oe5", t_oe[5], 0);
    wr(`A_DIR, 8'h20); @(negedge aclk);
    chk("out5", t_out[5], 1);
    wr(`A_CTL, 6'h20); ext <= 8'h80; repeat (3) @(posedge aclk);
    rd(`A_ACC); chk("acc", dd, 1);
    conclude;
  end
endmodule // tb_timer_capture_compare_unit
